// File: logic/bphc_defs.svh
// offsets, field positions, reset values and codes of the bridge config register bank
// Behaviour
// - two-bit power state reports D0 as 00 and D3 as 11 only
// - writes of codes 01 or 10 complete but leave power state unchanged
// - D3 to D0 change pulses internal chip reset, secondary reset untouched
// - power event enable and power event status bits always read zero
// - data select and data scale fields are read-only zero
// - bus state support and bus power clock enable read zero, writes ignored
// - hot-swap entry low byte returns capability identifier 0x6
// - hiding arm set by software writing 1, or at reset release with handle open
// - hiding arm cleared when hot-swap sequence enters its insertion state
// - interrupt mask 1 stops ENUM# drive, mask 0 allows it
// - pending insert/extract bit and programming interface field read zero
// - stored led control bit 1 lights the indicator, 0 darkens it
// - extraction flag set before removal, drives ENUM#, cleared by writing 1
// - insertion flag set after handle closed and reset gone, write 1 clears
// - legacy ISA enable 0 means legacy I/O ranges are neither claimed nor forwarded
// - legacy ISA enable 1 forwards the four legacy I/O ranges
`ifndef BPHC_DEFS_SVH
`define BPHC_DEFS_SVH

// register offsets (byte addresses, dword aligned)
`define BPHC_OFS_PM_CTRL_STATUS 8'h84
`define BPHC_OFS_HOTSWAP        8'h90
`define BPHC_OFS_MISC_CONTROL   8'hc0

// power state encodings
`define BPHC_PWR_D0             2'h0
`define BPHC_PWR_D3             2'h3
`define BPHC_PWR_RESET          2'h0

// hot-swap dword fields
`define BPHC_HS_CAP_ID          8'h06
`define BPHC_HS_NEXT_PTR        8'h00
`define BPHC_HS_ARM_BIT         16
`define BPHC_HS_MASK_BIT        17
`define BPHC_HS_LED_BIT         19
`define BPHC_HS_EXTRACT_BIT     22
`define BPHC_HS_INSERT_BIT      23

// edges after reset release before the synchronised handle shows the pin
`define BPHC_SYNC_SETTLE        2'h2

// misc control field
`define BPHC_MISC_ISA_BIT       8

// legacy ISA I/O windows, inclusive bounds
`define BPHC_ISA_GAME_LO        16'h0200
`define BPHC_ISA_GAME_HI        16'h0207
`define BPHC_ISA_FM_LO          16'h0388
`define BPHC_ISA_FM_HI          16'h038b
`define BPHC_ISA_AUDIO_LO       16'h0220
`define BPHC_ISA_AUDIO_HI       16'h0233
`define BPHC_ISA_MIDI_LO        16'h0330
`define BPHC_ISA_MIDI_HI        16'h0331

`endif

// File: logic/bphc_pkg.sv
// types shared by the bridge config register bank
package bphc_pkg;
    typedef logic [7:0]  bphc_addr_t;
    typedef logic [31:0] bphc_word_t;
    typedef logic [1:0]  bphc_pwr_t;
    typedef logic [15:0] bphc_io_addr_t;
endpackage : bphc_pkg

// File: logic/bphc_sync.sv
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module bphc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,     // domain clock
    input  wire logic             rst,     // synchronous reset, high
    input  wire logic [WIDTH-1:0] async_in, // level from a pin
    output logic      [WIDTH-1:0] sync_out  // level safe for logic
);
    logic [WIDTH-1:0] stage1_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule : bphc_sync

// File: logic/bphc_regs.sv
// power management, hot-swap and misc control configuration registers of the bridge
`timescale 1ns/100ps
`include "bphc_defs.svh"
module bphc_regs
    import bphc_pkg::*;
(
    input  wire logic          CLK,            // primary bus clock, 200 MHz
    input  wire logic          RST,            // primary bus reset, sync, high
    input  wire logic          CFG_WR,         // config write strobe, one cycle
    input  wire logic          CFG_RD,         // config read strobe, one cycle
    input  wire bphc_addr_t    CFG_ADDR,       // config byte address, low bits ignored
    input  wire logic [3:0]    CFG_BE_N,       // byte enables, active low
    input  wire bphc_word_t    CFG_WDATA,      // write data
    output bphc_word_t         CFG_RDATA,      // read data, registered
    output logic               CFG_RVALID,     // read data valid pulse
    input  wire logic          HANDLE_OPEN,    // ejector handle open, async pin
    input  wire logic          HS_INSERT_STATE, // hot-swap sequence in insertion state
    output logic               ENUM_N_O,       // enum pin output value
    output logic               ENUM_N_OE,      // enum pin drive enable
    output logic               LED_ON,         // indicator led drive
    output logic               CHIP_RESET,     // internal chip reset pulse
    output logic               LEGACY_ISA_EN,  // legacy ISA forwarding enabled
    input  wire logic          IO_REQ,         // primary I/O access present
    input  wire bphc_io_addr_t IO_ADDR,        // primary I/O address
    output logic               ISA_CLAIM       // claim and forward to secondary
);

    // register state
    bphc_pwr_t  power_state_field_reg;
    logic       arm_reg;
    logic       mask_reg;
    logic       led_reg;
    logic       extract_reg;
    logic       insert_reg;
    logic       isa_en_reg;
    logic [1:0] settle_reg;
    logic       handle_prev_reg;

    // decoded access
    bphc_addr_t dw_addr;
    logic       wr_pm;
    logic       wr_hs;
    logic       wr_misc;
    logic       handle_open_s;
    logic       hs_closed_event;
    logic       hs_open_at_start;
    logic       hs_open_event;
    logic       settle_first;
    logic       settle_done;
    logic       isa_hit;
    bphc_word_t rd_word;

    // ejector handle comes from a pin
    bphc_sync #(
        .WIDTH(1)
    ) u_handle_sync (
        .clk      (CLK),
        .rst      (RST),
        .async_in (HANDLE_OPEN),
        .sync_out (handle_open_s)
    );

    // dword address and per-register write qualifiers
    assign dw_addr = {CFG_ADDR[7:2], 2'b00};

    always_comb
    begin
        wr_pm   = 1'b0;
        wr_hs   = 1'b0;
        wr_misc = 1'b0;
        if (CFG_WR && dw_addr == `BPHC_OFS_PM_CTRL_STATUS)
        begin
            wr_pm = !CFG_BE_N[0];
        end
        else if (CFG_WR && dw_addr == `BPHC_OFS_HOTSWAP)
        begin
            wr_hs = !CFG_BE_N[2];
        end
        else if (CFG_WR && dw_addr == `BPHC_OFS_MISC_CONTROL)
        begin
            wr_misc = !CFG_BE_N[1];
        end
    end

    // waits out the synchroniser after reset, then keeps the last handle level
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            settle_reg      <= 2'h0;
            handle_prev_reg <= 1'b0;
        end
        else
        begin
            if (settle_reg <= `BPHC_SYNC_SETTLE)
            begin
                settle_reg <= settle_reg + 2'h1;
            end
            handle_prev_reg <= handle_open_s;
        end
    end

    // synchroniser is cleared by reset, so the first true handle level comes late
    assign settle_first = settle_reg == `BPHC_SYNC_SETTLE;
    assign settle_done  = settle_reg > `BPHC_SYNC_SETTLE;

    // handle events seen after primary reset is gone
    assign hs_closed_event  = !handle_open_s &&
                              (settle_first || (settle_done && handle_prev_reg));
    assign hs_open_at_start = handle_open_s && settle_first;
    assign hs_open_event    = handle_open_s && settle_done && !handle_prev_reg;

    // power state: only D0 and D3 are accepted
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            power_state_field_reg <= `BPHC_PWR_RESET;
        end
        else if (wr_pm && (CFG_WDATA[1:0] == `BPHC_PWR_D0 ||
                           CFG_WDATA[1:0] == `BPHC_PWR_D3))
        begin
            power_state_field_reg <= CFG_WDATA[1:0]; // codes 01 and 10 dropped
        end
    end

    // chip reset pulse on D3 to D0, secondary reset not involved
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            CHIP_RESET <= 1'b0;
        end
        else
        begin
            CHIP_RESET <= wr_pm && power_state_field_reg == `BPHC_PWR_D3 &&
                          CFG_WDATA[1:0] == `BPHC_PWR_D0;
        end
    end

    // device hiding arm: hardware set wins over any clear
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            arm_reg <= 1'b0;
        end
        else if (hs_open_at_start || (wr_hs && CFG_WDATA[`BPHC_HS_ARM_BIT]))
        begin
            arm_reg <= 1'b1;
        end
        else if (HS_INSERT_STATE)
        begin
            arm_reg <= 1'b0;
        end
        else if (wr_hs)
        begin
            arm_reg <= 1'b0;
        end
    end

    // interrupt mask and led control
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            mask_reg <= 1'b0;
            led_reg  <= 1'b0;
        end
        else if (wr_hs)
        begin
            mask_reg <= CFG_WDATA[`BPHC_HS_MASK_BIT];
            led_reg  <= CFG_WDATA[`BPHC_HS_LED_BIT];
        end
    end

    // extraction flag: set on handle opening, write 1 clears, set wins
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            extract_reg <= 1'b0;
        end
        else if (hs_open_event)
        begin
            extract_reg <= 1'b1;
        end
        else if (wr_hs && CFG_WDATA[`BPHC_HS_EXTRACT_BIT])
        begin
            extract_reg <= 1'b0;
        end
    end

    // insertion flag: set once handle closed with reset released
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            insert_reg <= 1'b0;
        end
        else if (hs_closed_event)
        begin
            insert_reg <= 1'b1;
        end
        else if (wr_hs && CFG_WDATA[`BPHC_HS_INSERT_BIT])
        begin
            insert_reg <= 1'b0;
        end
    end

    // enum open-drain pin, only ever pulls low
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ENUM_N_O  <= 1'b1;
            ENUM_N_OE <= 1'b0;
        end
        else
        begin
            ENUM_N_O  <= 1'b0;
            ENUM_N_OE <= (insert_reg || extract_reg) && !mask_reg;
        end
    end

    // led pin follows stored control bit
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            LED_ON <= 1'b0;
        end
        else
        begin
            LED_ON <= led_reg;
        end
    end

    // legacy ISA enable, only bit 8 is writable
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            isa_en_reg <= 1'b0;
        end
        else if (wr_misc)
        begin
            isa_en_reg <= CFG_WDATA[`BPHC_MISC_ISA_BIT];
        end
    end

    // legacy I/O window match
    always_comb
    begin
        isa_hit = 1'b0;
        if (IO_ADDR >= `BPHC_ISA_GAME_LO && IO_ADDR <= `BPHC_ISA_GAME_HI)
        begin
            isa_hit = 1'b1;
        end
        else if (IO_ADDR >= `BPHC_ISA_FM_LO && IO_ADDR <= `BPHC_ISA_FM_HI)
        begin
            isa_hit = 1'b1;
        end
        else if (IO_ADDR >= `BPHC_ISA_AUDIO_LO && IO_ADDR <= `BPHC_ISA_AUDIO_HI)
        begin
            isa_hit = 1'b1;
        end
        else if (IO_ADDR >= `BPHC_ISA_MIDI_LO && IO_ADDR <= `BPHC_ISA_MIDI_HI)
        begin
            isa_hit = 1'b1;
        end
    end

    // claim decision and enable level for the forwarding path
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ISA_CLAIM     <= 1'b0;
            LEGACY_ISA_EN <= 1'b0;
        end
        else
        begin
            ISA_CLAIM     <= IO_REQ && isa_hit && isa_en_reg;
            LEGACY_ISA_EN <= isa_en_reg;
        end
    end

    // read mux, unimplemented and reserved fields return zero
    always_comb
    begin
        rd_word = '0;
        if (dw_addr == `BPHC_OFS_PM_CTRL_STATUS)
        begin
            rd_word[1:0] = power_state_field_reg;
        end
        else if (dw_addr == `BPHC_OFS_HOTSWAP)
        begin
            rd_word[7:0]                 = `BPHC_HS_CAP_ID;
            rd_word[15:8]                = `BPHC_HS_NEXT_PTR;
            rd_word[`BPHC_HS_ARM_BIT]     = arm_reg;
            rd_word[`BPHC_HS_MASK_BIT]    = mask_reg;
            rd_word[`BPHC_HS_LED_BIT]     = led_reg; // bits 18,21,20 zero
            rd_word[`BPHC_HS_EXTRACT_BIT] = extract_reg;
            rd_word[`BPHC_HS_INSERT_BIT]  = insert_reg;
        end
        else if (dw_addr == `BPHC_OFS_MISC_CONTROL)
        begin
            rd_word[`BPHC_MISC_ISA_BIT]  = isa_en_reg;
        end
    end

    // registered read answer, byte enables only gate writes
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            CFG_RDATA  <= '0;
            CFG_RVALID <= 1'b0;
        end
        else
        begin
            CFG_RVALID <= CFG_RD;
            if (CFG_RD)
            begin
                CFG_RDATA <= rd_word;
            end
        end
    end

endmodule : bphc_regs

// File: test/bphc_regs_asserts.sv
// port assertions of the config register bank
`timescale 1ns/100ps
module bphc_regs_asserts
    import bphc_pkg::*;
(
    input wire logic          CLK,           // clock
    input wire logic          RST,           // reset
    input wire logic          CFG_WR,        // write
    input wire logic          CFG_RD,        // read
    input wire bphc_addr_t    CFG_ADDR,      // address
    input wire logic [3:0]    CFG_BE_N,      // lanes
    input wire bphc_word_t    CFG_WDATA,     // write data
    input wire bphc_word_t    CFG_RDATA,     // read data
    input wire logic          CFG_RVALID,    // read valid
    input wire logic          ENUM_N_OE,     // enum drive
    input wire logic          LED_ON,        // led
    input wire logic          CHIP_RESET,    // chip reset
    input wire logic          LEGACY_ISA_EN, // isa enable
    input wire logic          IO_REQ,        // io access
    input wire bphc_io_addr_t IO_ADDR,       // io address
    input wire logic          ISA_CLAIM      // claim
);
    logic [5:0] ofs_reg;

    // dword of the last read
    always_ff @(posedge CLK)
        if (CFG_RD)
            ofs_reg <= CFG_ADDR[7:2];

    // legacy window decode
    function automatic logic hit(input bphc_io_addr_t a);
        return (a >= 16'h0200 && a <= 16'h0207) || (a >= 16'h0388 && a <= 16'h038b)
            || (a >= 16'h0220 && a <= 16'h0233) || (a >= 16'h0330 && a <= 16'h0331);
    endfunction : hit

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_pm_zero: assert property (
        CFG_RVALID && ofs_reg == 6'h21 |-> CFG_RDATA[31:2] == 30'h0
        && CFG_RDATA[0] == CFG_RDATA[1]) else $error("power word wrong");
    a_hs_fixed: assert property (
        CFG_RVALID && ofs_reg == 6'h24 |-> CFG_RDATA[15:0] == 16'h0006
        && CFG_RDATA[21:20] == 2'h0 && !CFG_RDATA[18]) else $error("hot-swap fixed bits");
    a_misc_zero: assert property (
        CFG_RVALID && ofs_reg == 6'h30 |-> CFG_RDATA[31:9] == 23'h0
        && CFG_RDATA[7:0] == 8'h0) else $error("misc reserved bits");
    a_chip_cause: assert property (
        CHIP_RESET |-> $past(CFG_WR) && $past(CFG_ADDR[7:2]) == 6'h21
        && !$past(CFG_BE_N[0]) && $past(CFG_WDATA[1:0]) == 2'h0) else $error("stray reset");
    a_chip_pulse: assert property (
        CHIP_RESET |=> !CHIP_RESET) else $error("reset too long");
    a_led_match: assert property (
        CFG_RVALID && ofs_reg == 6'h24 |-> LED_ON == CFG_RDATA[19]) else $error("led");
    a_enum_follow: assert property (
        CFG_RVALID && ofs_reg == 6'h24 |-> ENUM_N_OE ==
        (!CFG_RDATA[17] && (CFG_RDATA[22] || CFG_RDATA[23]))) else $error("enum drive");
    a_claim_cause: assert property (
        ISA_CLAIM |-> $past(IO_REQ) && hit($past(IO_ADDR)) && LEGACY_ISA_EN)
        else $error("bad claim");
    a_claim_hit: assert property (
        IO_REQ && LEGACY_ISA_EN && hit(IO_ADDR) |=> ISA_CLAIM) else $error("missed claim");

    c_chip: cover property (CHIP_RESET);
    c_claim: cover property (ISA_CLAIM);
    c_enum: cover property (ENUM_N_OE ##1 !ENUM_N_OE);
endmodule : bphc_regs_asserts

// File: test/bphc_cfg_master.sv
// config master on the primary bus
`timescale 1ns/100ps
module bphc_cfg_master
    import bphc_pkg::*;
(
    input  wire logic       CLK,        // clock
    output logic            CFG_WR,     // write
    output logic            CFG_RD,     // read
    output bphc_addr_t      CFG_ADDR,   // address
    output logic [3:0]      CFG_BE_N,   // lanes
    output bphc_word_t      CFG_WDATA,  // write data
    input  wire bphc_word_t CFG_RDATA,  // read data
    input  wire logic       CFG_RVALID  // read valid
);
    // idle bus from time zero
    initial
    begin
        {CFG_WR, CFG_RD, CFG_ADDR, CFG_BE_N, CFG_WDATA} = '0;
    end

    // one write strobe, then lines scrambled so no stale value lingers
    task automatic wr(input bphc_addr_t a, input logic [3:0] be, input bphc_word_t d);
        @(negedge CLK);
        {CFG_WR, CFG_ADDR, CFG_BE_N, CFG_WDATA} <= {1'b1, a, be, d};
        @(negedge CLK);
        {CFG_WR, CFG_ADDR, CFG_BE_N, CFG_WDATA} <= {1'b0, ~a, ~be, ~d};
    endtask : wr

    // one read strobe, answer taken in the following cycle
    task automatic rd(input bphc_addr_t a, output bphc_word_t q, output logic v);
        @(negedge CLK);
        {CFG_RD, CFG_ADDR} <= {1'b1, a};
        @(negedge CLK);
        {CFG_RD, CFG_ADDR} <= {1'b0, ~a};
        q = CFG_RDATA;
        v = CFG_RVALID;
    endtask : rd
endmodule : bphc_cfg_master

// File: test/bphc_regs_tb.sv
// testbench of the config register bank
`timescale 1ns/100ps
`include "bphc_defs.svh"
module bphc_regs_tb
    import bphc_pkg::*;
;
    logic          CLK, RST, CFG_WR, CFG_RD, CFG_RVALID, v;
    logic          HANDLE_OPEN, HS_INSERT_STATE, IO_REQ, ISA_CLAIM;
    logic          ENUM_N_O, ENUM_N_OE, LED_ON, CHIP_RESET, LEGACY_ISA_EN;
    logic [3:0]    CFG_BE_N;
    bphc_addr_t    CFG_ADDR;
    bphc_word_t    CFG_WDATA, CFG_RDATA, q;
    bphc_io_addr_t IO_ADDR;
    int            error_cnt, n_checks;
    bphc_io_addr_t adr [16] = '{16'h0200, 16'h0207, 16'h0208, 16'h01ff, 16'h0388, 16'h038b,
        16'h038c, 16'h0387, 16'h0220, 16'h0233, 16'h0234, 16'h021f, 16'h0330, 16'h0331,
        16'h0332, 16'h032f};

    bphc_regs u_bphc_regs (.CLK, .RST, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_BE_N, .CFG_WDATA,
        .CFG_RDATA, .CFG_RVALID, .HANDLE_OPEN, .HS_INSERT_STATE, .ENUM_N_O, .ENUM_N_OE,
        .LED_ON, .CHIP_RESET, .LEGACY_ISA_EN, .IO_REQ, .IO_ADDR, .ISA_CLAIM);
    bphc_cfg_master u_bphc_cfg_master (.CLK, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_BE_N,
        .CFG_WDATA, .CFG_RDATA, .CFG_RVALID);

    // 200 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    // compare and count
    task automatic chk(input bphc_word_t got, input bphc_word_t exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // read and compare
    task automatic rdc(input bphc_addr_t a, input bphc_word_t exp);
        u_bphc_cfg_master.rd(a, q, v);
        chk(32'(v), 32'h1);
        chk(q, exp);
    endtask : rdc

    // one io access, claim seen the next cycle
    task automatic io(input bphc_io_addr_t a, input logic exp);
        @(negedge CLK);
        IO_REQ = 1'b1;
        IO_ADDR = a;
        @(negedge CLK);
        IO_REQ = 1'b0;
        IO_ADDR = ~a;
        chk(32'(ISA_CLAIM), 32'(exp));
    endtask : io

    // reset with the handle at a given level
    task automatic rst_dut(input logic h);
        @(negedge CLK);
        RST = 1'b1;
        HANDLE_OPEN = h;
        repeat (16) @(negedge CLK);
        RST = 1'b0;
        repeat (4) @(negedge CLK);
    endtask : rst_dut

    // legacy window decode
    function automatic logic hit(input bphc_io_addr_t a);
        return (a >= `BPHC_ISA_GAME_LO && a <= `BPHC_ISA_GAME_HI)
            || (a >= `BPHC_ISA_FM_LO && a <= `BPHC_ISA_FM_HI)
            || (a >= `BPHC_ISA_AUDIO_LO && a <= `BPHC_ISA_AUDIO_HI)
            || (a >= `BPHC_ISA_MIDI_LO && a <= `BPHC_ISA_MIDI_HI);
    endfunction : hit

    // counts and verdict
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // hang guard
    initial
    begin
        #10000;
        error_cnt++;
        wrap_up();
    end

    // test sequence
    initial
    begin
        {HANDLE_OPEN, HS_INSERT_STATE, IO_REQ, IO_ADDR} = '0;
        RST = 1'b1;
        error_cnt = 0;
        n_checks = 0;
        rst_dut(1'b0);
        chk(32'(ENUM_N_OE), 32'h1); // boot insert
        chk(32'(ENUM_N_O), 32'h0); // pin only pulls low
        rdc(8'h90, 32'h0080_0006); // boot flags
        rdc(8'h84, 32'h0); // reset state
        u_bphc_cfg_master.wr(8'h44, 4'h0, 32'hffff_ffff);
        rdc(8'h44, 32'h0);
        u_bphc_cfg_master.wr(8'h84, 4'he, 32'h3);
        rdc(8'h84, 32'h3); // sleep
        for (int i = 1; i < 3; i++)
        begin
            u_bphc_cfg_master.wr(8'h84, 4'he, 32'(i));
            rdc(8'h84, 32'h3); // dropped
        end
        u_bphc_cfg_master.wr(8'h84, 4'h0, 32'hffff_fffc);
        chk(32'(CHIP_RESET), 32'h1); // wake
        @(negedge CLK);
        chk(32'(CHIP_RESET), 32'h0); // pulse
        rdc(8'h84, 32'h0); // fixed zeros
        u_bphc_cfg_master.wr(8'h84, 4'hf, 32'h3);
        rdc(8'h84, 32'h0); // lane off
        u_bphc_cfg_master.wr(8'h90, 4'hb, 32'h0002_0000);
        rdc(8'h90, 32'h0082_0006); // masked
        chk(32'(ENUM_N_OE), 32'h0); // masked
        u_bphc_cfg_master.wr(8'h90, 4'hb, 32'h0080_0000);
        rdc(8'h90, 32'h6); // cleared
        u_bphc_cfg_master.wr(8'h90, 4'hb, 32'hffff_ffff);
        rdc(8'h90, 32'h000b_0006); // arm and led
        chk(32'(LED_ON), 32'h1); // lit
        HS_INSERT_STATE = 1'b1;
        @(negedge CLK);
        HS_INSERT_STATE = 1'b0;
        rdc(8'h90, 32'h000a_0006); // arm dropped
        u_bphc_cfg_master.wr(8'h90, 4'hb, 32'h0);
        rdc(8'h90, 32'h6);
        chk(32'(LED_ON), 32'h0); // dark
        HANDLE_OPEN = 1'b1;
        repeat (5) @(negedge CLK);
        chk(32'(ENUM_N_OE), 32'h1); // extraction
        rdc(8'h90, 32'h0040_0006); // extraction
        u_bphc_cfg_master.wr(8'h90, 4'hb, 32'h0040_0000);
        rdc(8'h90, 32'h6); // cleared
        HANDLE_OPEN = 1'b0;
        repeat (5) @(negedge CLK);
        rdc(8'h90, 32'h0080_0006); // insertion
        rst_dut(1'b1);
        rdc(8'h90, 32'h0001_0006); // armed at boot
        u_bphc_cfg_master.wr(8'hc0, 4'hd, 32'hffff_ffff);
        rdc(8'hc0, 32'h100); // reserved
        for (int e = 1; e >= 0; e--)
        begin
            u_bphc_cfg_master.wr(8'hc0, 4'hd, 32'(e) << 8);
            foreach (adr[k])
                io(adr[k], e[0] && hit(adr[k])); // windows
            chk(32'(LEGACY_ISA_EN), 32'(e)); // enable level
        end
        wrap_up();
    end
endmodule : bphc_regs_tb

bind bphc_regs bphc_regs_asserts u_bphc_regs_asserts (.CLK, .RST, .CFG_WR, .CFG_RD,
    .CFG_ADDR, .CFG_BE_N, .CFG_WDATA, .CFG_RDATA, .CFG_RVALID, .ENUM_N_OE, .LED_ON,
    .CHIP_RESET, .LEGACY_ISA_EN, .IO_REQ, .IO_ADDR, .ISA_CLAIM);
